// *** include/exec_pkg.sv ***
// shared constants, register map and opcode encoding of the execution unit
package exec_pkg;

  // ----------------------------------------------------------------
  // instruction encoding presented by the decoder
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NOP                = 3'h0,
    OP_INCR_SKIP_ZERO     = 3'h1,
    OP_UNCOND_BRANCH      = 3'h2,
    OP_OR_LITERAL_ACC     = 3'h3,
    OP_INCR_FILE          = 3'h4,
    OP_OR_ACC_FILE        = 3'h5,
    OP_SHIFT_LEFT_LOGICAL = 3'h6
  } op_e;

  localparam int unsigned PC_W = 15;
  localparam int unsigned BRANCH_K_W = 11;
  localparam int unsigned PAGE_W = 7;
  localparam int unsigned FADDR_W = 7;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ACC_OFS = 8'h04;
  localparam logic [7:0] FLAGS_OFS = 8'h08;
  localparam logic [7:0] PAGE_OFS = 8'h0c;
  localparam logic [7:0] PC_OFS = 8'h10;

  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned FLAGS_C_BIT = 0;
  localparam int unsigned FLAGS_Z_BIT = 1;
  localparam int unsigned PAGE_HI_BIT = 6;
  localparam int unsigned PAGE_LO_BIT = 3;

  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [PAGE_W-1:0] PAGE_RST = 7'h00;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

endpackage

// *** core/alu_exec.sv ***
// combinational result, destination and flag logic for one instruction
`timescale 1ns/1ns
module alu_exec
  import exec_pkg::*;
(
  input wire op_e op,
  input wire logic [7:0] file_val,
  input wire logic [7:0] acc,
  input wire logic [BRANCH_K_W-1:0] lit,
  input wire logic dest,
  output logic [7:0] result,
  output logic wr_acc,
  output logic wr_file,
  output logic upd_z,
  output logic upd_c,
  output logic carry_out,
  output logic is_branch,
  output logic skip_next
);

  always_comb begin
    result = 8'h00;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    carry_out = 1'b0;
    is_branch = 1'b0;
    skip_next = 1'b0;
    case (op)
      OP_INCR_SKIP_ZERO: begin
        result = file_val + 8'h01;
        wr_acc = (dest == DEST_ACC);
        wr_file = (dest == DEST_FILE);
        skip_next = (result == 8'h00);
      end
      OP_UNCOND_BRANCH: begin
        is_branch = 1'b1;
      end
      OP_OR_LITERAL_ACC: begin
        result = acc | lit[7:0];
        wr_acc = 1'b1;
        upd_z = 1'b1;
      end
      // increment with zero flag; 0xff wraps to zero
      OP_INCR_FILE: begin
        result = file_val + 8'h01;
        wr_acc = (dest == DEST_ACC);
        wr_file = (dest == DEST_FILE);
        upd_z = 1'b1;
      end
      OP_OR_ACC_FILE: begin
        result = acc | file_val;
        wr_acc = (dest == DEST_ACC);
        wr_file = (dest == DEST_FILE);
        upd_z = 1'b1;
      end
      OP_SHIFT_LEFT_LOGICAL: begin
        result = {file_val[6:0], 1'b0};
        carry_out = file_val[7];
        upd_c = 1'b1;
        upd_z = 1'b1;
        wr_acc = (dest == DEST_ACC);
        wr_file = (dest == DEST_FILE);
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

endmodule

// *** core/exec_unit.sv ***
// execution unit: six core instructions, program counter and ahb-lite registers
// How it works
// - increment-and-skip adds one, writes acc or file by select, no flags.
// - skip instruction: zero result turns next instruction into a nop.
// - branch loads its 11-bit immediate into pc bits 10..0.
// - branch fills pc bits 14..11 from page latch bits 6..3.
// - branch takes two cycles and leaves flags unchanged.
// - or-literal ors acc with 8-bit literal into acc, updates zero.
// - plain increment writes acc or file by select, updates zero.
// - or-with-file ors acc and file, routes by select, updates zero.
// - left shift: bit 7 to carry, zero into bit 0, carry and zero updated.
// - left shift result goes to acc or file by select.
//
// Register access over AHB-Lite and the address map are this design's own decisions.
`timescale 1ns/1ns
module exec_unit
  import exec_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic [2:0] instr_op,
  input wire logic [FADDR_W-1:0] instr_f,
  input wire logic instr_d,
  input wire logic [BRANCH_K_W-1:0] instr_k,
  input wire logic [7:0] file_rd_data,
  output logic instr_ready,
  output logic file_wr_en,
  output logic [FADDR_W-1:0] file_wr_addr,
  output logic [7:0] file_wr_data,
  output logic [PC_W-1:0] pc,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // execution datapath
  // ----------------------------------------------------------------
  typedef enum logic {ST_RUN, ST_NOP} seq_e;

  seq_e seq_q, seq_d;
  logic [PC_W-1:0] pc_q, pc_d;
  logic [7:0] acc_q, acc_d;
  logic carry_q, carry_d;
  logic zero_q, zero_d;
  logic [PAGE_W-1:0] page_q, page_d;
  logic en_q, en_d;
  logic ready_q, ready_d;
  logic fwe_q, fwe_d;
  logic [FADDR_W-1:0] fwa_q, fwa_d;
  logic [7:0] fwd_q, fwd_d;

  logic take;
  logic [7:0] alu_result;
  logic alu_wr_acc;
  logic alu_wr_file;
  logic alu_upd_z;
  logic alu_upd_c;
  logic alu_carry;
  logic alu_branch;
  logic alu_skip;
  logic [PC_W-1:0] br_target;

  // software writes, applied in the bus data phase
  logic sw_wr;
  logic [7:0] sw_addr;

  assign take = instr_valid && ready_q;
  assign br_target = {page_q[PAGE_HI_BIT:PAGE_LO_BIT], instr_k};

  alu_exec u_alu (
    .op(op_e'(instr_op)),
    .file_val(file_rd_data),
    .acc(acc_q),
    .lit(instr_k),
    .dest(instr_d),
    .result(alu_result),
    .wr_acc(alu_wr_acc),
    .wr_file(alu_wr_file),
    .upd_z(alu_upd_z),
    .upd_c(alu_upd_c),
    .carry_out(alu_carry),
    .is_branch(alu_branch),
    .skip_next(alu_skip)
  );

  // instruction writes beat a software write in the same cycle
  always_comb begin
    seq_d = ST_RUN;
    pc_d = pc_q;
    acc_d = acc_q;
    carry_d = carry_q;
    zero_d = zero_q;
    page_d = page_q;
    en_d = en_q;
    fwe_d = 1'b0;
    fwa_d = fwa_q;
    fwd_d = fwd_q;
    if (sw_wr) begin
      case (sw_addr)
        CTRL_OFS: en_d = hwdata[CTRL_EN_BIT];
        ACC_OFS: acc_d = hwdata[7:0];
        FLAGS_OFS: begin
          carry_d = hwdata[FLAGS_C_BIT];
          zero_d = hwdata[FLAGS_Z_BIT];
        end
        PAGE_OFS: page_d = hwdata[PAGE_W-1:0];
        default: en_d = en_q;
      endcase
    end
    case (seq_q)
      ST_RUN: begin
        if (take) begin
          if (alu_branch) begin
            pc_d = br_target;
            seq_d = ST_NOP;
          end else if (alu_skip) begin
            pc_d = pc_q + 15'h0002;
            seq_d = ST_NOP;
          end else begin
            pc_d = pc_q + 15'h0001;
          end
          if (alu_wr_acc) begin
            acc_d = alu_result;
          end
          if (alu_wr_file) begin
            fwe_d = 1'b1;
            fwa_d = instr_f;
            fwd_d = alu_result;
          end
          if (alu_upd_z) begin
            zero_d = (alu_result == 8'h00);
          end
          if (alu_upd_c) begin
            carry_d = alu_carry;
          end
        end
      end
      ST_NOP: seq_d = ST_RUN;
      default: seq_d = ST_RUN;
    endcase
    // accept only in run state, and never while disabled
    ready_d = en_d && (seq_d == ST_RUN);
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      seq_q <= ST_RUN;
      pc_q <= PC_RST;
      acc_q <= ACC_RST;
      carry_q <= 1'b0;
      zero_q <= 1'b0;
      page_q <= PAGE_RST;
      en_q <= CTRL_EN_RST;
      ready_q <= 1'b0;
      fwe_q <= 1'b0;
      fwa_q <= '0;
      fwd_q <= 8'h00;
    end else begin
      seq_q <= seq_d;
      pc_q <= pc_d;
      acc_q <= acc_d;
      carry_q <= carry_d;
      zero_q <= zero_d;
      page_q <= page_d;
      en_q <= en_d;
      ready_q <= ready_d;
      fwe_q <= fwe_d;
      fwa_q <= fwa_d;
      fwd_q <= fwd_d;
    end
  end

  assign instr_ready = ready_q;
  assign file_wr_en = fwe_q;
  assign file_wr_addr = fwa_q;
  assign file_wr_data = fwd_q;
  assign pc = pc_q;

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  // reads insert one wait so hrdata can leave a flop and see prior writes
  logic wr_pend_q, wr_pend_d;
  logic rd_pend_q, rd_pend_d;
  logic [7:0] addr_q, addr_d;
  logic hready_q, hready_d;
  logic [31:0] rdata_q, rdata_d;
  logic addr_phase;

  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign sw_wr = wr_pend_q;
  assign sw_addr = addr_q;

  always_comb begin
    wr_pend_d = addr_phase && hwrite;
    rd_pend_d = addr_phase && !hwrite;
    addr_d = addr_phase ? haddr[7:0] : addr_q;
    hready_d = !rd_pend_d;
    rdata_d = rdata_q;
    if (rd_pend_q) begin
      case (addr_q)
        CTRL_OFS: rdata_d = {31'h0, en_q};
        ACC_OFS: rdata_d = {24'h0, acc_q};
        FLAGS_OFS: rdata_d = {30'h0, zero_q, carry_q};
        PAGE_OFS: rdata_d = {25'h0, page_q};
        PC_OFS: rdata_d = {17'h0, pc_q};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hready_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wr_pend_q <= wr_pend_d;
      rd_pend_q <= rd_pend_d;
      addr_q <= addr_d;
      hready_q <= hready_d;
      rdata_q <= rdata_d;
    end
  end

  assign hreadyout = hready_q;
  assign hrdata = rdata_q;
  assign hresp = HRESP_OKAY;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic take_br;
  logic take_skip;
  logic take_file;

  assign take_br = take && alu_branch;
  assign take_skip = take && (op_e'(instr_op) == OP_INCR_SKIP_ZERO);
  assign take_file = take && alu_wr_file;

  a_branch_target: assert property (
    @(posedge core_clk) disable iff (!rst_n_q)
    take_br |=> pc == {$past(page_q[PAGE_HI_BIT:PAGE_LO_BIT]), $past(instr_k)})
    else $error("branch target wrong");

  a_branch_low_bits: assert property (
    @(posedge core_clk) disable iff (!rst_n_q)
    take_br |=> pc[BRANCH_K_W-1:0] == $past(instr_k))
    else $error("branch immediate not loaded");

  a_branch_two_cycle: assert property (
    @(posedge core_clk) disable iff (!rst_n_q)
    take_br |=> !instr_ready && $stable(carry_q) && $stable(zero_q))
    else $error("branch not two cycles or flags moved");

  a_skip_nop: assert property (
    @(posedge core_clk) disable iff (!rst_n_q)
    (take_skip && alu_result == 8'h00) |=> !instr_ready ##0 pc == $past(pc) + 15'h0002)
    else $error("zero skip not taken");

  a_skip_flags: assert property (
    @(posedge core_clk) disable iff (!rst_n_q)
    take_skip |=> $stable(zero_q) && $stable(carry_q))
    else $error("skip instruction moved flags");

  a_single_cycle: assert property (
    @(posedge core_clk) disable iff (!rst_n_q)
    (take && !alu_branch && !alu_skip) |=> pc == $past(pc) + 15'h0001)
    else $error("pc not advanced by one");

  a_zero_flag: assert property (
    @(posedge core_clk) disable iff (!rst_n_q)
    (take && alu_upd_z) |=> zero_q == ($past(alu_result) == 8'h00))
    else $error("zero flag wrong");

  a_or_literal: assert property (
    @(posedge core_clk) disable iff (!rst_n_q)
    (take && op_e'(instr_op) == OP_OR_LITERAL_ACC) |=>
      acc_q == ($past(acc_q) | $past(instr_k[7:0])))
    else $error("or literal result wrong");

  a_shift_carry: assert property (
    @(posedge core_clk) disable iff (!rst_n_q)
    (take && op_e'(instr_op) == OP_SHIFT_LEFT_LOGICAL) |=>
      carry_q == $past(file_rd_data[7]) &&
      $past(alu_result) == {$past(file_rd_data[6:0]), 1'b0})
    else $error("shift carry wrong");

  a_file_dest: assert property (
    @(posedge core_clk) disable iff (!rst_n_q)
    (take_file && instr_d == DEST_FILE) |=>
      file_wr_en && file_wr_addr == $past(instr_f) && file_wr_data == $past(alu_result))
    else $error("file write missing");

  a_acc_dest: assert property (
    @(posedge core_clk) disable iff (!rst_n_q)
    (take && alu_wr_acc && op_e'(instr_op) == OP_OR_ACC_FILE) |=>
      acc_q == ($past(acc_q) | $past(file_rd_data)) && !file_wr_en)
    else $error("or to acc wrong");

  a_incr_wrap: assert property (
    @(posedge core_clk) disable iff (!rst_n_q)
    (take && op_e'(instr_op) == OP_INCR_FILE && file_rd_data == 8'hff) |=> zero_q)
    else $error("increment wrap not zero");

  c_branch: cover property (@(posedge core_clk) disable iff (!rst_n_q) take_br);
  c_skip_zero: cover property (@(posedge core_clk) disable iff (!rst_n_q)
    take_skip && alu_skip);
  c_shift_carry: cover property (@(posedge core_clk) disable iff (!rst_n_q)
    take && alu_upd_c && alu_carry);
  c_bus_read: cover property (@(posedge core_clk) disable iff (!rst_n_q)
    rd_pend_q ##1 hreadyout);

endmodule

// *** verification/file_mem_model.sv ***
// bench-side model of the decoder's file-register memory
`timescale 1ns/1ns
module file_mem_model
  import exec_pkg::*;
(
  input wire logic core_clk,
  input wire logic instr_valid,
  input wire logic [FADDR_W-1:0] instr_f,
  input wire logic file_wr_en,
  input wire logic [FADDR_W-1:0] file_wr_addr,
  input wire logic [7:0] file_wr_data,
  output logic [7:0] file_rd_data
);
  logic [7:0] mem [128];
  logic [7:0] junk_q = 8'h00;

  // plain always: the bench preloads mem by hierarchical writes, which always_ff forbids
  always @(posedge core_clk) begin
    junk_q <= junk_q + 8'h5b;
    if (file_wr_en) begin
      mem[file_wr_addr] <= file_wr_data;
    end
  end

  // no offered instruction: a moving pattern, so stale data never looks right
  assign file_rd_data = instr_valid ? mem[instr_f] : junk_q;
endmodule

// *** verification/testbench.sv ***
// self-checking testbench of the execution unit
`timescale 1ns/1ns
module testbench;
  import exec_pkg::*;
  logic core_clk, reset_n, instr_valid, instr_d, instr_ready, file_wr_en;
  logic [2:0] instr_op;
  logic [FADDR_W-1:0] instr_f, file_wr_addr;
  logic [BRANCH_K_W-1:0] instr_k;
  logic [7:0] file_rd_data, file_wr_data;
  logic [PC_W-1:0] pc, exp_pc;
  logic hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, last_rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int bad_count, n_tests;

  exec_unit exec_unit_inst (.core_clk(core_clk), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_f(instr_f), .instr_d(instr_d), .instr_k(instr_k),
    .file_rd_data(file_rd_data), .instr_ready(instr_ready), .file_wr_en(file_wr_en),
    .file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data), .pc(pc), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  file_mem_model file_mem_model_inst (.core_clk(core_clk), .instr_valid(instr_valid),
    .instr_f(instr_f), .file_wr_en(file_wr_en), .file_wr_addr(file_wr_addr),
    .file_wr_data(file_wr_data), .file_rd_data(file_rd_data));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (bad_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // waits for a ready flag sampled high at a falling edge, bounded
  task automatic wait_hi(input bit use_bus);
    logic ok;
    ok = 1'b0;
    for (int n = 0; n < 50 && !ok; n++) begin
      @(negedge core_clk);
      ok = use_bus ? (hreadyout === 1'b1) : (instr_ready === 1'b1);
      last_rd = hrdata;
      @(posedge core_clk);
    end
    if (!ok) begin
      bad_count++;
      print_verdict();
    end
  endtask

  // ----------------------------------------------------------------
  // ahb-lite single word transfers
  // ----------------------------------------------------------------
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    wait_hi(1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_hi(1'b1);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), last_rd, e);
  endtask

  // ----------------------------------------------------------------
  // one instruction from the decoder side
  // ----------------------------------------------------------------
  task automatic run(input logic [2:0] op, input logic [6:0] f, input logic d,
                     input logic [10:0] k, input logic we, input logic [7:0] wd,
                     input logic rdy);
    @(posedge core_clk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_f <= f;
    instr_d <= d;
    instr_k <= k;
    wait_hi(1'b0);
    instr_valid <= 1'b0;
    @(negedge core_clk);
    chk("pc", {17'h0, pc}, {17'h0, exp_pc});
    chk("instr_ready", {31'h0, instr_ready}, {31'h0, rdy});
    chk("file_wr_en", {31'h0, file_wr_en}, {31'h0, we});
    if (we) begin
      chk("file_wr", {17'h0, file_wr_addr, file_wr_data}, {17'h0, f, wd});
    end
  endtask

  logic [7:0] ofs [6] = '{CTRL_OFS, ACC_OFS, FLAGS_OFS, PAGE_OFS, PC_OFS, 8'h20};
  logic [31:0] rst_val [6] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  initial begin
    reset_n = 1'b0;
    {instr_valid, instr_d, hsel, hwrite} = 4'h0;
    {instr_op, instr_f, instr_k} = '0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    bad_count = 0;
    n_tests = 0;
    exp_pc = '0;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    ahb(1'b1, 8'h20, 32'hffff_ffff);
    for (int i = 0; i < 6; i++) begin
      rdchk(ofs[i], rst_val[i]);
    end
    chk("hresp", {31'h0, hresp}, {31'h0, HRESP_OKAY});
    file_mem_model_inst.mem[3] = 8'hff;
    file_mem_model_inst.mem[4] = 8'h41;
    file_mem_model_inst.mem[5] = 8'h81;
    file_mem_model_inst.mem[6] = 8'h80;
    file_mem_model_inst.mem[7] = 8'h41;
    file_mem_model_inst.mem[8] = 8'hff;
    file_mem_model_inst.mem[9] = 8'h10;
    exp_pc = 15'h1;
    run(OP_OR_LITERAL_ACC, 7'h0, 1'b0, 11'h700, 1'b0, 8'h0, 1'b1);
    rdchk(FLAGS_OFS, 32'h2);
    exp_pc = 15'h2;
    run(OP_OR_LITERAL_ACC, 7'h0, 1'b0, 11'h75a, 1'b0, 8'h0, 1'b1);
    rdchk(ACC_OFS, 32'h5a);
    rdchk(FLAGS_OFS, 32'h0);
    exp_pc = 15'h3;
    run(OP_INCR_FILE, 7'h3, 1'b1, 11'h0, 1'b1, 8'h00, 1'b1);
    rdchk(FLAGS_OFS, 32'h2);
    rdchk(ACC_OFS, 32'h5a);
    exp_pc = 15'h4;
    run(OP_INCR_FILE, 7'h4, 1'b0, 11'h0, 1'b0, 8'h0, 1'b1);
    rdchk(ACC_OFS, 32'h42);
    exp_pc = 15'h5;
    run(OP_OR_ACC_FILE, 7'h5, 1'b1, 11'h0, 1'b1, 8'hc3, 1'b1);
    exp_pc = 15'h6;
    run(OP_OR_ACC_FILE, 7'h5, 1'b0, 11'h0, 1'b0, 8'h0, 1'b1);
    rdchk(ACC_OFS, 32'hc3);
    rdchk(FLAGS_OFS, 32'h0);
    exp_pc = 15'h7;
    run(OP_SHIFT_LEFT_LOGICAL, 7'h6, 1'b0, 11'h0, 1'b0, 8'h0, 1'b1);
    rdchk(ACC_OFS, 32'h0);
    rdchk(FLAGS_OFS, 32'h3);
    exp_pc = 15'h8;
    run(OP_SHIFT_LEFT_LOGICAL, 7'h7, 1'b1, 11'h0, 1'b1, 8'h82, 1'b1);
    rdchk(FLAGS_OFS, 32'h0);
    ahb(1'b1, FLAGS_OFS, 32'h3);
    exp_pc = 15'ha;
    run(OP_INCR_SKIP_ZERO, 7'h8, 1'b1, 11'h0, 1'b1, 8'h00, 1'b0);
    rdchk(FLAGS_OFS, 32'h3);
    exp_pc = 15'hb;
    run(OP_INCR_SKIP_ZERO, 7'h9, 1'b0, 11'h0, 1'b0, 8'h0, 1'b1);
    rdchk(ACC_OFS, 32'h11);
    ahb(1'b1, PAGE_OFS, 32'h58);
    exp_pc = {4'hb, 11'h2a5};
    run(OP_UNCOND_BRANCH, 7'h0, 1'b0, 11'h2a5, 1'b0, 8'h0, 1'b0);
    rdchk(PC_OFS, {17'h0, 4'hb, 11'h2a5});
    rdchk(FLAGS_OFS, 32'h3);
    exp_pc = {4'hb, 11'h2a6};
    run(OP_NOP, 7'h0, 1'b0, 11'h0, 1'b0, 8'h0, 1'b1);
    ahb(1'b1, CTRL_OFS, 32'h0);
    @(negedge core_clk);
    chk("instr_ready", {31'h0, instr_ready}, 32'h0);
    rdchk(CTRL_OFS, 32'h0);
    ahb(1'b1, CTRL_OFS, 32'h1);
    @(negedge core_clk);
    chk("instr_ready", {31'h0, instr_ready}, 32'h1);
    print_verdict();
  end
endmodule
